// ### logic/mcu_core_pkg.sv
package mcu_core_pkg;

  localparam int IW = 16;
  localparam int DW = 8;
  localparam int AW = 13;
  localparam int FAW = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SPW = 3;

  // register map on the apb side
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TBLPTR_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ACC_OFS = 8'h0c;
  localparam logic [7:0] PROGCTR_OFS = 8'h10;

  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_NIBBLE_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_SLEEPFLAG_BIT = 3;
  localparam int STAT_WDEXP_BIT = 4;
  localparam int STAT_ASLEEP_BIT = 5;

  localparam logic RUN_RST = 1'b1;
  localparam logic WDEXP_RST = 1'b1;
  localparam logic SLEEPFLAG_RST = 1'b1;
  localparam logic [AW-1:0] VECTOR_RST = 13'h0000;

  // whole-word encodings
  localparam logic [IW-1:0] WORD_SUB_RETURN = 16'h0040;
  localparam logic [IW-1:0] WORD_INT_RETURN = 16'h0060;
  localparam logic [IW-1:0] WORD_LOOKUP_LOW = 16'h0050;
  localparam logic [IW-1:0] WORD_LOOKUP_HIGH = 16'h0058;
  localparam logic [IW-1:0] WORD_ZERO_ACC = 16'h0140;
  localparam logic [IW-1:0] WORD_POWER_DOWN = 16'h1e03;
  localparam logic [IW-1:0] WORD_WATCHDOG_KICK = 16'h1e04;

  localparam logic [1:0] GRP_BYTE = 2'b00;
  localparam logic [1:0] GRP_LIT = 2'b01;
  localparam logic [1:0] GRP_BRANCH = 2'b10;
  localparam logic [1:0] GRP_BIT = 2'b11;

  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_ZERO = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_COPY = 4'h8;
  localparam logic [3:0] OP_INV = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RR = 4'hc;
  localparam logic [3:0] OP_RL = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;

  localparam logic [3:0] LIT_RETURN = 4'h8;
  localparam logic [3:0] LIT_LOAD = 4'h9;
  localparam logic [3:0] LIT_OR = 4'ha;
  localparam logic [3:0] LIT_AND = 4'hb;
  localparam logic [3:0] LIT_ADD = 4'hc;
  localparam logic [3:0] LIT_XOR = 4'hd;
  localparam logic [3:0] LIT_SYS = 4'he;
  localparam logic [3:0] LIT_SUB = 4'hf;

  localparam logic [1:0] BOP_CLR = 2'b00;
  localparam logic [1:0] BOP_SET = 2'b01;
  localparam logic [1:0] BOP_SKIP_LOW = 2'b10;
  localparam logic [1:0] BOP_SKIP_HIGH = 2'b11;

  typedef enum logic [3:0] {
    ST_EXEC = 4'b0001,
    ST_SKIP = 4'b0010,
    ST_BUBBLE = 4'b0100,
    ST_TABLE = 4'b1000
  } core_state_t;

  // returns {carry, nibble carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : add8

endpackage : mcu_core_pkg

// ### logic/file_ram.sv
`timescale 1ns/1ns
module file_ram
  import mcu_core_pkg::*;
(
  input wire logic pclk, // core clock
  input wire logic we, // write strobe
  input wire logic [FAW-1:0] waddr, // write address
  input wire logic [DW-1:0] wdata, // write byte
  input wire logic [FAW-1:0] raddr, // read address
  output logic [DW-1:0] rdata // read byte, same cycle
);

  // data memory is left unreset; software initialises what it uses
  logic [DW-1:0] mem [0:(1<<FAW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule : file_ram

// ### logic/mcu_core.sv
`timescale 1ns/1ns
module mcu_core
  import mcu_core_pkg::*;
(
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic [AW-1:0] prog_addr, // program memory address
  input wire logic [IW-1:0] prog_rdata, // program word at prog_addr
  output logic watchdog_clear, // one-cycle watchdog restart
  output logic sleep_active // core in power-down
);

  typedef struct packed {
    core_state_t state;
    logic [AW-1:0] program_counter;
    logic [AW-1:0] fetch;
    logic [DW-1:0] acc;
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic watchdog_expired_flag;
    logic sleep_status_flag;
    logic asleep;
    logic run;
    logic [AW-1:0] tblptr;
    logic [DW-1:0] table_read_latch;
    logic tbl_high;
    logic [STACK_DEPTH-1:0][AW-1:0] stack;
    logic [SPW-1:0] sp;
    logic ready;
    logic [31:0] rdata;
    logic slverr;
    logic wdt_clr;
  } core_t;

  core_t st_ff;
  core_t nxt_st;

  logic [DW-1:0] fval;
  logic [9:0] sum;
  logic [DW-1:0] res;
  logic to_acc;
  logic to_file;
  logic zf_upd;
  logic skip;
  logic go;
  logic execing;
  logic apb_access;
  logic apb_commit;

  // decoded fields
  // opcode groups
  wire [IW-1:0] instr = prog_rdata;
  wire [1:0] grp = instr[13:12];
  wire [3:0] op = instr[11:8];
  wire dbit = instr[7];
  wire [FAW-1:0] faddr = {instr[15:14], instr[6:0]};
  wire [2:0] bsel = instr[9:7];
  wire [1:0] bop = instr[11:10];
  wire [DW-1:0] lit = instr[7:0];
  wire [AW-1:0] tgt = {instr[15:14], instr[10:0]};
  wire lit_ok = (grp == GRP_LIT) && (instr[15:14] == 2'b00);

  assign go = st_ff.run && !st_ff.asleep;
  assign execing = go && (st_ff.state == ST_EXEC);
  assign apb_access = psel && penable && !st_ff.ready;
  // writes land only on the edge that completes the transfer
  assign apb_commit = psel && penable && st_ff.ready && pwrite;

  file_ram u_file_ram (
    .pclk(pclk),
    .we(to_file),
    .waddr(faddr),
    .wdata(res),
    .raddr(faddr),
    .rdata(fval)
  );

  always_comb begin
    nxt_st = st_ff;
    sum = '0;
    res = '0;
    to_acc = 1'b0;
    to_file = 1'b0;
    zf_upd = 1'b0;
    skip = 1'b0;
    nxt_st.wdt_clr = 1'b0;
    case (st_ff.state)
      ST_EXEC: begin
        if (go) begin
          nxt_st.program_counter = st_ff.program_counter + 13'd1;
          case (grp)
            GRP_BYTE: begin
              to_acc = !dbit;
              to_file = dbit;
              zf_upd = 1'b1;
              case (op)
                OP_MISC: begin
                  res = st_ff.acc;
                  to_acc = 1'b0;
                  zf_upd = 1'b0;
                  if (instr == WORD_SUB_RETURN || instr == WORD_INT_RETURN) begin
                    nxt_st.sp = st_ff.sp - 3'd1;
                    nxt_st.program_counter = st_ff.stack[st_ff.sp - 3'd1];
                    nxt_st.state = ST_BUBBLE;
                  end else if (instr == WORD_LOOKUP_LOW || instr == WORD_LOOKUP_HIGH) begin
                    nxt_st.tbl_high = (instr == WORD_LOOKUP_HIGH);
                    nxt_st.state = ST_TABLE;
                  end
                end
                OP_ZERO: begin
                  to_acc = (instr == WORD_ZERO_ACC);
                  zf_upd = to_acc || dbit;
                end
                OP_SUB: begin
                  sum = add8(fval, ~st_ff.acc, 1'b1);
                  res = sum[7:0];
                  nxt_st.carry = sum[9];
                  nxt_st.nibble_carry_flag = sum[8];
                end
                OP_ADD: begin
                  sum = add8(fval, st_ff.acc, 1'b0);
                  res = sum[7:0];
                  nxt_st.carry = sum[9];
                  nxt_st.nibble_carry_flag = sum[8];
                end
                OP_AND: res = fval & st_ff.acc;
                OP_OR: res = fval | st_ff.acc;
                OP_XOR: res = fval ^ st_ff.acc;
                OP_INV: res = ~fval;
                OP_DEC: res = fval - 8'd1;
                OP_INC: res = fval + 8'd1;
                OP_DECSZ: begin
                  res = fval - 8'd1;
                  zf_upd = 1'b0;
                  skip = (res == 8'h00);
                end
                OP_INCSZ: begin
                  res = fval + 8'd1;
                  zf_upd = 1'b0;
                  skip = (res == 8'h00);
                end
                OP_RL: begin
                  res = {fval[6:0], st_ff.carry};
                  nxt_st.carry = fval[7];
                  zf_upd = 1'b0;
                end
                OP_RR: begin
                  res = {st_ff.carry, fval[7:1]};
                  nxt_st.carry = fval[0];
                  zf_upd = 1'b0;
                end
                OP_SWAP: begin
                  res = {fval[3:0], fval[7:4]};
                  zf_upd = 1'b0;
                end
                default: begin
                  // copy or probe; probe writes nothing back
                  res = fval;
                  to_file = 1'b0;
                end
              endcase
            end
            GRP_LIT: begin
              if (lit_ok) begin
                to_acc = 1'b1;
                zf_upd = 1'b1;
                case (op)
                  LIT_ADD: begin
                    sum = add8(st_ff.acc, lit, 1'b0);
                    res = sum[7:0];
                    nxt_st.carry = sum[9];
                    nxt_st.nibble_carry_flag = sum[8];
                  end
                  LIT_SUB: begin
                    sum = add8(lit, ~st_ff.acc, 1'b1);
                    res = sum[7:0];
                    nxt_st.carry = sum[9];
                    nxt_st.nibble_carry_flag = sum[8];
                  end
                  LIT_AND: res = st_ff.acc & lit;
                  LIT_OR: res = st_ff.acc | lit;
                  LIT_XOR: res = st_ff.acc ^ lit;
                  LIT_LOAD: begin
                    res = lit;
                    zf_upd = 1'b0;
                  end
                  LIT_RETURN: begin
                    res = lit;
                    zf_upd = 1'b0;
                    nxt_st.sp = st_ff.sp - 3'd1;
                    nxt_st.program_counter = st_ff.stack[st_ff.sp - 3'd1];
                    nxt_st.state = ST_BUBBLE;
                  end
                  LIT_SYS: begin
                    to_acc = 1'b0;
                    zf_upd = 1'b0;
                    if (instr == WORD_POWER_DOWN) begin
                      nxt_st.asleep = 1'b1;
                      nxt_st.watchdog_expired_flag = 1'b1;
                      nxt_st.sleep_status_flag = 1'b0;
                    end else if (instr == WORD_WATCHDOG_KICK) begin
                      nxt_st.wdt_clr = 1'b1;
                      nxt_st.watchdog_expired_flag = 1'b1;
                      nxt_st.sleep_status_flag = 1'b1;
                    end
                  end
                  default: begin
                    to_acc = 1'b0;
                    zf_upd = 1'b0;
                  end
                endcase
              end
            end
            GRP_BRANCH: begin
              if (!instr[11]) begin
                nxt_st.stack[st_ff.sp] = st_ff.program_counter + 13'd1;
                nxt_st.sp = st_ff.sp + 3'd1;
              end
              nxt_st.program_counter = tgt;
              nxt_st.state = ST_BUBBLE;
            end
            default: begin
              res = fval;
              case (bop)
                BOP_CLR: begin
                  res[bsel] = 1'b0;
                  to_file = 1'b1;
                end
                BOP_SET: begin
                  res[bsel] = 1'b1;
                  to_file = 1'b1;
                end
                BOP_SKIP_LOW: skip = !fval[bsel];
                default: skip = fval[bsel];
              endcase
            end
          endcase
          if (zf_upd) begin
            nxt_st.zero = (res == 8'h00);
          end
          if (to_acc) begin
            nxt_st.acc = res;
          end
          if (skip) begin
            nxt_st.program_counter = st_ff.program_counter + 13'd2;
            nxt_st.state = ST_SKIP;
          end
          // lookup borrows the fetch port for one cycle
          nxt_st.fetch = (nxt_st.state == ST_TABLE) ? st_ff.tblptr
                                                    : nxt_st.program_counter;
        end
      end
      ST_TABLE: begin
        if (go) begin
          res = st_ff.tbl_high ? instr[15:8] : instr[7:0];
          nxt_st.acc = res;
          nxt_st.table_read_latch = res;
          nxt_st.fetch = st_ff.program_counter;
          nxt_st.state = ST_EXEC;
        end
      end
      default: begin
        // skip slot or branch bubble: the word on the bus is ignored
        if (go) begin
          nxt_st.state = ST_EXEC;
        end
      end
    endcase

    // apb slave: answer one cycle into the access phase
    nxt_st.ready = apb_access;
    nxt_st.slverr = 1'b0;
    if (apb_access) begin
      nxt_st.rdata = '0;
      if (paddr == CTRL_OFS) begin
        nxt_st.rdata[CTRL_RUN_BIT] = st_ff.run;
      end else if (paddr == TBLPTR_OFS) begin
        nxt_st.rdata = {19'h0, st_ff.tblptr};
      end else if (paddr == STATUS_OFS) begin
        nxt_st.rdata[STAT_CARRY_BIT] = st_ff.carry;
        nxt_st.rdata[STAT_NIBBLE_BIT] = st_ff.nibble_carry_flag;
        nxt_st.rdata[STAT_ZERO_BIT] = st_ff.zero;
        nxt_st.rdata[STAT_SLEEPFLAG_BIT] = st_ff.sleep_status_flag;
        nxt_st.rdata[STAT_WDEXP_BIT] = st_ff.watchdog_expired_flag;
        nxt_st.rdata[STAT_ASLEEP_BIT] = st_ff.asleep;
      end else if (paddr == ACC_OFS) begin
        nxt_st.rdata = {16'h0, st_ff.table_read_latch, st_ff.acc};
      end else if (paddr == PROGCTR_OFS) begin
        nxt_st.rdata = {19'h0, st_ff.program_counter};
      end else begin
        nxt_st.slverr = 1'b1;
      end
    end
    // software wins over a power-down in the same cycle, so a wake is never lost
    if (apb_commit) begin
      if (paddr == CTRL_OFS) begin
        nxt_st.run = pwdata[CTRL_RUN_BIT];
        if (pwdata[CTRL_RUN_BIT]) begin
          nxt_st.asleep = 1'b0;
        end
      end else if (paddr == TBLPTR_OFS) begin
        nxt_st.tblptr = pwdata[AW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.state <= ST_EXEC;
      st_ff.program_counter <= VECTOR_RST;
      st_ff.fetch <= VECTOR_RST;
      st_ff.run <= RUN_RST;
      st_ff.watchdog_expired_flag <= WDEXP_RST;
      st_ff.sleep_status_flag <= SLEEPFLAG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign prog_addr = st_ff.fetch;
  assign watchdog_clear = st_ff.wdt_clr;
  assign sleep_active = st_ff.asleep;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_byte_dest: assert property (
    (execing && grp == GRP_BYTE && op == OP_INC) |-> (to_file == dbit)
      ##1 (st_ff.acc == ($past(dbit) ? $past(st_ff.acc) : $past(fval) + 8'd1)))
    else $error("byte op destination wrong");

  a_add_flags: assert property (
    (execing && lit_ok && op == LIT_ADD) |=>
      ({st_ff.carry, st_ff.acc} == {1'b0, $past(st_ff.acc)} + {1'b0, $past(lit)}))
    else $error("literal add result or carry wrong");

  a_nibble_carry: assert property (
    (execing && lit_ok && op == LIT_ADD) |=> (st_ff.nibble_carry_flag ==
      (({1'b0, $past(st_ff.acc[3:0])} + {1'b0, $past(lit[3:0])}) > 5'd15)))
    else $error("nibble carry wrong");

  a_skip_slot: assert property (
    (execing && skip) |=> (st_ff.state == ST_SKIP) && !to_file
      ##1 (st_ff.acc == $past(st_ff.acc)))
    else $error("skipped word was executed");

  a_branch_two: assert property (
    (execing && grp == GRP_BRANCH) |=> (st_ff.state == ST_BUBBLE)
      && (prog_addr == $past(tgt)) && $stable(st_ff.carry) && $stable(st_ff.zero))
    else $error("branch target or timing wrong");

  a_call_push: assert property (
    (execing && grp == GRP_BRANCH && !instr[11]) |=>
      (st_ff.sp == $past(st_ff.sp) + 3'd1)
      && (st_ff.stack[$past(st_ff.sp)] == $past(st_ff.program_counter) + 13'd1))
    else $error("call did not push return address");

  a_return_pop: assert property (
    (execing && (instr == WORD_SUB_RETURN || instr == WORD_INT_RETURN)) |=>
      (st_ff.sp == $past(st_ff.sp) - 3'd1) && (st_ff.state == ST_BUBBLE))
    else $error("return did not pop");

  a_bit_clear: assert property (
    (execing && grp == GRP_BIT && bop == BOP_CLR) |-> to_file && !res[bsel]
      ##1 $stable(st_ff.zero) && $stable(st_ff.carry))
    else $error("bit clear wrong");

  a_table_load: assert property (
    (go && st_ff.state == ST_TABLE) |=>
      (st_ff.acc == ($past(st_ff.tbl_high) ? $past(instr[15:8]) : $past(instr[7:0])))
      && (st_ff.acc == st_ff.table_read_latch) && (prog_addr == st_ff.program_counter))
    else $error("lookup byte not loaded");

endmodule : mcu_core

// ### dv/prog_mem.sv
`timescale 1ns/1ns
module prog_mem
  import mcu_core_pkg::*;
(
  input wire logic [AW-1:0] prog_addr, // fetch address
  output logic [IW-1:0] prog_rdata // word at prog_addr
);
  logic [IW-1:0] mem [0:31];
  // same-cycle fetch; beyond the small image every word reads as a no-op
  assign prog_rdata = (prog_addr < 13'd32) ? mem[prog_addr[4:0]] : 16'h0000;
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'h0000;
    end
  end
endmodule : prog_mem

// ### dv/mcu_instruction_decode_execute_test.sv
`timescale 1ns/1ns
module mcu_instruction_decode_execute_test;
  import mcu_core_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic watchdog_clear, sleep_active;
  logic [7:0] paddr, k1, k2, k3, a1;
  logic [31:0] pwdata, prdata, rd;
  logic [AW-1:0] prog_addr;
  logic [IW-1:0] prog_rdata;
  logic [8:0] f;
  logic [12:0] tp;
  int num_errors, checked, kicks, n;
  // call into the lookup subroutine; table pointer is 0 after reset, so the lookup reads this word
  localparam logic [IW-1:0] CALL_WORD = 16'h200d;

  mcu_core dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .watchdog_clear(watchdog_clear), .sleep_active(sleep_active));
  prog_mem prog(.prog_addr(prog_addr), .prog_rdata(prog_rdata));

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) kicks <= 0;
    else if (watchdog_clear === 1'b1) kicks <= kicks + 1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // accumulator register: lookup latch above, difference unless the skip did not happen
  function automatic logic [31:0] exp_acc(input logic [7:0] lit, input logic [7:0] sum);
    logic [7:0] d;
    d = lit - sum;
    return {16'h0, CALL_WORD[15:8], sum[7] ? d : 8'haa};
  endfunction : exp_acc

  // status after power-down, arithmetic flags from the literal subtract
  function automatic logic [31:0] exp_status(input logic [7:0] lit, input logic [7:0] sum);
    logic [8:0] d;
    d = {1'b0, lit} - {1'b0, sum};
    return {26'h0, 3'b110, d[7:0] == 8'h00, lit[3:0] >= sum[3:0], ~d[8]};
  endfunction : exp_status

  task conclude;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask : apb

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    checked = 0;
    void'($urandom(1388));
    for (int it = 0; it < 6; it++) begin
      // corner cases first: zero result with carries, then a taken skip with borrow
      if (it == 0) begin
        k1 = 8'hff;
        k2 = 8'h01;
        k3 = 8'h00;
        f = 9'h1ff;
      end else if (it == 1) begin
        k1 = 8'h88;
        k2 = 8'h08;
        k3 = 8'h10;
        f = 9'h000;
      end else begin
        k1 = 8'($urandom);
        k2 = 8'($urandom);
        k3 = 8'($urandom);
        f = 9'($urandom);
      end
      presetn <= 0;
      repeat (20) @(posedge pclk);
      prog.mem[0] = CALL_WORD;
      prog.mem[1] = {8'h19, k1};
      prog.mem[2] = {8'h1c, k2};
      prog.mem[3] = {f[8:7], 7'b0000001, f[6:0]};
      prog.mem[4] = {8'h1f, k3};
      prog.mem[5] = {f[8:7], 7'b1111111, f[6:0]};
      prog.mem[6] = 16'h19aa;
      prog.mem[7] = 16'h2809;
      prog.mem[8] = 16'h19ff;
      // bit 14 set: not a literal word, so the accumulator must not move
      prog.mem[9] = 16'h5cff;
      prog.mem[10] = WORD_WATCHDOG_KICK;
      prog.mem[11] = WORD_POWER_DOWN;
      prog.mem[12] = 16'h280c;
      // subroutine: lookup, store, clear bit 5, increment into acc, return
      prog.mem[13] = WORD_LOOKUP_HIGH;
      prog.mem[14] = {f[8:7], 7'b0000001, f[6:0]};
      prog.mem[15] = {f[8:7], 7'b1100101, f[6:0]};
      prog.mem[16] = {f[8:7], 7'b0010100, f[6:0]};
      prog.mem[17] = WORD_SUB_RETURN;
      presetn <= 1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sleep_active !== 1'b1 && n < 100);
      a1 = k1 + k2;
      check(sleep_active, 32'h1, "asleep");
      apb(0, ACC_OFS, 32'h0);
      check(rd, exp_acc(k3, a1), "acc");
      apb(0, STATUS_OFS, 32'h0);
      check(rd, exp_status(k3, a1), "status");
      tp = 13'($urandom);
      apb(1, TBLPTR_OFS, {19'h0, tp});
      apb(0, TBLPTR_OFS, 32'h0);
      check(rd, {19'h0, tp}, "tblptr");
      apb(0, 8'h20, 32'h0);
      check(err, 32'h1, "unmapped");
      apb(1, CTRL_OFS, 32'h1);
      repeat (3) @(posedge pclk);
      check(sleep_active, 32'h0, "awake");
      apb(0, PROGCTR_OFS, 32'h0);
      check(rd, 32'hc, "pc");
      check(kicks, 32'h1, "kicks");
    end
    conclude();
  end
endmodule : mcu_instruction_decode_execute_test
